// ### window_gate_defines.svh
`ifndef WINDOW_GATE_DEFINES_SVH
`define WINDOW_GATE_DEFINES_SVH
`define ADDR_CONTROL 32'h0000_0000
`define ADDR_STATUS 32'h0000_0004
`define CTRL_GATED_MODE 0
`define CTRL_BEGIN_POL 1
`define CTRL_END_POL 2
`define CTRL_COND_POL 3
`define CTRL_CLOCK_POL 4
`define CTRL_REG_ENABLE 5
`define CTRL_WINDOW_CLEAR 6
`define CTRL_RESET 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### window_gate_pkg.sv
package window_gate_pkg;
    typedef enum logic [2:0]
    {
        WIN_IDLE = 3'h1,
        WIN_OPEN = 3'h2,
        WIN_DONE = 3'h4
    } win_state_t;
endpackage

// ### window_gate.sv
// Behaviour
// - normal mode: begin from begin pin, end from condition
// - gated mode: both events from begin pin
// - begin path always carries begin pin
// - end selector: inverted condition or begin pin
// - independent polarity on begin and end paths
// - condition polarity applied before synchronizer
// - gated mode samples condition on selected clock
// - synchronizer held high when not gated
// - clock polarity inverts pod clock
// - two complementary clock edges used
// - free running synchronous window machine
// - events accepted only in fixed order
// - window clear returns machine to idle
// - after clear only begin admitted
// - after begin only end admitted
// - after end everything blocked until clear
// - true window to shifter and indicator
// - shifter clock needs enable, window, condition
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`include "window_gate_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module window_gate
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pod_begin_input,
    input wire logic pod_end_input,
    input wire logic pod_clock,
    output logic window_indicator,
    output logic window_n,
    output logic shift_enable,
    output logic shift_clock,
    output logic cond_sync,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [6:0] ctrl_r;
    logic [31:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic clk_prev_r;
    logic begin_lvl_r;
    logic begin_prev_r;
    logic end_lvl_r;
    logic end_prev_r;
    logic cond_sync_r;
    window_gate_pkg::win_state_t state_r;
    window_gate_pkg::win_state_t state_nxt;
    logic gated_mode;
    logic sel_clock;
    logic rise_edge;
    logic fall_edge;
    logic begin_path;
    logic end_path;
    logic cond_path;
    logic begin_ev;
    logic end_ev;
    logic window;
    logic do_write;
    // word decode: the two low address bits never pick a register
    function automatic logic word_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
        word_hit = (addr[31:2] == reg_addr[31:2]);
    endfunction
    // bus pins: awready/wready while not holding and no write response pending
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held_r <= 1'b0;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held_r <= 1'b0;
        end
    end
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= 7'(`CTRL_RESET);
        end
        else if (do_write && word_hit(awaddr_r, `ADDR_CONTROL) && wstrb_r[0])
        begin
            ctrl_r <= wdata_r[6:0];
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= word_hit(awaddr_r, `ADDR_CONTROL) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            if (word_hit(s_axi_araddr, `ADDR_CONTROL))
            begin
                s_axi_rdata <= {25'h0000000, ctrl_r};
            end
            else if (word_hit(s_axi_araddr, `ADDR_STATUS))
            begin
                s_axi_rdata <= {27'h0000000, cond_sync_r, state_r, window};
            end
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // pod pins pass two flops before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end
        else
        begin
            pin_s1_r <= {pod_clock, pod_end_input, pod_begin_input};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign gated_mode = ctrl_r[`CTRL_GATED_MODE];
    assign sel_clock = pin_s2_r[2] ^ ctrl_r[`CTRL_CLOCK_POL];
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_prev_r <= 1'b0;
        end
        else
        begin
            clk_prev_r <= sel_clock;
        end
    end
    // rising edge of selected clock runs the window; falling edge is the complement clock
    assign rise_edge = sel_clock && !clk_prev_r;
    assign fall_edge = !sel_clock && clk_prev_r;
    assign begin_path = pin_s2_r[0] ^ ctrl_r[`CTRL_BEGIN_POL];
    assign end_path = (gated_mode ? pin_s2_r[0] : !pin_s2_r[1]) ^ ctrl_r[`CTRL_END_POL];
    assign cond_path = pin_s2_r[1] ^ ctrl_r[`CTRL_COND_POL];
    // levels captured on the clock edge so each event lasts one selected-clock period
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            begin_lvl_r <= 1'b0;
            begin_prev_r <= 1'b0;
            end_lvl_r <= 1'b0;
            end_prev_r <= 1'b0;
        end
        else if (rise_edge)
        begin
            begin_lvl_r <= begin_path;
            begin_prev_r <= begin_lvl_r;
            end_lvl_r <= end_path;
            end_prev_r <= end_lvl_r;
        end
    end
    assign begin_ev = begin_lvl_r && !begin_prev_r;
    assign end_ev = end_lvl_r && !end_prev_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !gated_mode)
        begin
            cond_sync_r <= 1'b1;
        end
        else if (fall_edge)
        begin
            cond_sync_r <= cond_path;
        end
    end
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            window_gate_pkg::WIN_IDLE:
            begin
                if (begin_ev)
                begin
                    state_nxt = window_gate_pkg::WIN_OPEN;
                end
            end
            window_gate_pkg::WIN_OPEN:
            begin
                if (end_ev)
                begin
                    state_nxt = window_gate_pkg::WIN_DONE;
                end
            end
            window_gate_pkg::WIN_DONE:
            begin
                state_nxt = window_gate_pkg::WIN_DONE;
            end
            default:
            begin
                state_nxt = window_gate_pkg::WIN_IDLE;
            end
        endcase
    end
    // the clear is a level held by software; clearing needs no clock edge from the pod
    always_ff @(posedge aclk)
    begin
        if (!aresetn || ctrl_r[`CTRL_WINDOW_CLEAR])
        begin
            state_r <= window_gate_pkg::WIN_IDLE;
        end
        else if (rise_edge)
        begin
            state_r <= state_nxt;
        end
    end
    assign window = (state_r == window_gate_pkg::WIN_OPEN);
    assign window_indicator = window;
    assign window_n = !window;
    assign cond_sync = cond_sync_r;
    assign shift_enable = ctrl_r[`CTRL_REG_ENABLE] && window && cond_sync_r;
    assign shift_clock = shift_enable && !sel_clock;

    idle_end_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == window_gate_pkg::WIN_IDLE && !begin_ev |=> state_r == window_gate_pkg::WIN_IDLE
        || $past(ctrl_r[`CTRL_WINDOW_CLEAR]) == 1'b0 && $past(rise_edge) == 1'b0)
        else $error("window left idle without begin");
    done_stays_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == window_gate_pkg::WIN_DONE && !ctrl_r[`CTRL_WINDOW_CLEAR] |=> state_r == window_gate_pkg::WIN_DONE)
        else $error("done state left without clear");
    clear_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_r[`CTRL_WINDOW_CLEAR] |=> state_r == window_gate_pkg::WIN_IDLE)
        else $error("clear did not reach idle");
    open_on_begin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == window_gate_pkg::WIN_IDLE && begin_ev && rise_edge && !ctrl_r[`CTRL_WINDOW_CLEAR]
        |=> state_r == window_gate_pkg::WIN_OPEN)
        else $error("begin did not open window");
    sync_preset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !gated_mode |=> cond_sync_r)
        else $error("condition not preset");
    shift_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        shift_clock == (ctrl_r[`CTRL_REG_ENABLE] && state_r == window_gate_pkg::WIN_OPEN
            && cond_sync_r && !sel_clock))
        else $error("shift gating wrong");
    end_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        gated_mode && !ctrl_r[`CTRL_END_POL] |-> end_path == (begin_path ^ ctrl_r[`CTRL_BEGIN_POL]))
        else $error("end path not from begin pin");
    complement_a: assert property (@(posedge aclk) disable iff (!aresetn)
        window_n != window_indicator)
        else $error("window outputs not complementary");
endmodule
`default_nettype wire

// ### pod_model.sv
`timescale 1ns/100ps
`default_nettype none
module pod_model
(
    input wire logic run,
    input wire logic beg_cmd,
    input wire logic end_cmd,
    output var logic pod_clock,
    output var logic pod_begin_input,
    output var logic pod_end_input
);
    // probe clock stands still between frames; levels move away from both edges
    initial
    begin
        pod_clock = 1'b0;
        pod_begin_input = 1'b0;
        pod_end_input = 1'b0;
        #13;
        forever
        begin
            if (run)
            begin
                pod_begin_input = beg_cmd;
                pod_end_input = end_cmd;
                #100 pod_clock = 1'b1;
                #200 pod_clock = 1'b0;
                #100;
            end
            else
            begin
                #50;
            end
        end
    end
endmodule
`default_nettype wire

// ### test_window_gate.sv
`include "window_gate_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module test_window_gate;
    localparam logic [2:0] ID = window_gate_pkg::WIN_IDLE;
    localparam logic [2:0] OP = window_gate_pkg::WIN_OPEN;
    localparam logic [2:0] DN = window_gate_pkg::WIN_DONE;
    logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, beg_cmd = 1'b0, end_cmd = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic pod_clock, pod_begin_input, pod_end_input, window_indicator, window_n;
    logic shift_enable, shift_clock, cond_sync, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, tmp;
    logic b, cp, kp, c;
    int err_count = 0;
    int num_checks = 0;
    integer seed = 94;
    always #25 aclk = ~aclk;
    pod_model pod (.run, .beg_cmd, .end_cmd, .pod_clock, .pod_begin_input, .pod_end_input);
    window_gate uut (.aclk, .aresetn, .pod_begin_input, .pod_end_input, .pod_clock,
        .window_indicator, .window_n, .shift_enable, .shift_clock, .cond_sync,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang;
        err_count++;
        report_and_stop;
    endtask
    function automatic logic [31:0] ctl(input logic g, bp, ep, qp, clp, en, clr);
        ctl = 32'h0;
        ctl[`CTRL_GATED_MODE] = g;
        ctl[`CTRL_BEGIN_POL] = bp;
        ctl[`CTRL_END_POL] = ep;
        ctl[`CTRL_COND_POL] = qp;
        ctl[`CTRL_CLOCK_POL] = clp;
        ctl[`CTRL_REG_ENABLE] = en;
        ctl[`CTRL_WINDOW_CLEAR] = clr;
    endfunction
    function automatic logic [31:0] sw(input logic w, input logic [2:0] s, input logic q);
        sw = {27'h0, q, s, w};
    endfunction
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) hang;
        chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        logic [31:0] d;
        logic [1:0] rr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            rr = s_axi_rresp;
            if (s_axi_rvalid) break;
        end
        if (n == 50) hang;
        s_axi_rready <= 1'b0;
        chk("rdata", e, d);
        chk("rresp", {30'h0, r}, {30'h0, rr});
        @(posedge aclk);
    endtask
    task automatic step(input int n);
        run = 1'b1;
        repeat (n * 8) @(posedge aclk);
        run = 1'b0;
        repeat (12) @(posedge aclk);
    endtask
    // clear is level-held while the probe clock runs, so it spans real edges
    task automatic clear(input logic [31:0] c0);
        wr(`ADDR_CONTROL, c0 | ctl(0, 0, 0, 0, 0, 0, 1));
        step(2);
        wr(`ADDR_CONTROL, c0);
        step(2);
    endtask
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ADDR_CONTROL, `CTRL_RESET, `RESP_OKAY);
        rd(`ADDR_STATUS, sw(0, ID, 1), `RESP_OKAY);
        rd(32'h0000_0010, 32'h0, `RESP_SLVERR);
        end_cmd = 1'b1;
        clear(ctl(0, 0, 0, 0, 0, 1, 0));
        end_cmd = 1'b0;
        step(3);
        rd(`ADDR_STATUS, sw(0, ID, 1), `RESP_OKAY);
        end_cmd = 1'b1;
        beg_cmd = 1'b1;
        step(3);
        rd(`ADDR_STATUS, sw(1, OP, 1), `RESP_OKAY);
        chk("window_n", 32'h0, {31'h0, window_n});
        chk("shift_enable", 32'h1, {31'h0, shift_enable});
        chk("shift_clock", 32'h1, {31'h0, shift_clock});
        chk("cond_sync", 32'h1, {31'h0, cond_sync});
        beg_cmd = 1'b0;
        step(2);
        beg_cmd = 1'b1;
        step(3);
        rd(`ADDR_STATUS, sw(1, OP, 1), `RESP_OKAY);
        end_cmd = 1'b0;
        step(3);
        rd(`ADDR_STATUS, sw(0, DN, 1), `RESP_OKAY);
        chk("window_indicator", 32'h0, {31'h0, window_indicator});
        end_cmd = 1'b1;
        beg_cmd = 1'b0;
        step(2);
        beg_cmd = 1'b1;
        step(3);
        rd(`ADDR_STATUS, sw(0, DN, 1), `RESP_OKAY);
        clear(ctl(0, 0, 0, 0, 0, 1, 0));
        rd(`ADDR_STATUS, sw(0, ID, 1), `RESP_OKAY);
        for (int i = 0; i < 6; i++)
        begin
            tmp = $random(seed);
            {c, kp, cp, b} = tmp[3:0];
            beg_cmd = b;
            end_cmd = c;
            clear(ctl(1, b, !b, cp, kp, 1, 0));
            rd(`ADDR_STATUS, sw(0, ID, c ^ cp), `RESP_OKAY);
            beg_cmd = !b;
            step(3);
            rd(`ADDR_STATUS, sw(1, OP, c ^ cp), `RESP_OKAY);
            chk("shift_enable", {31'h0, c ^ cp}, {31'h0, shift_enable});
            chk("shift_clock", {31'h0, (c ^ cp) & !kp}, {31'h0, shift_clock});
            chk("cond_sync", {31'h0, c ^ cp}, {31'h0, cond_sync});
            beg_cmd = b;
            step(3);
            rd(`ADDR_STATUS, sw(0, DN, c ^ cp), `RESP_OKAY);
        end
        // register enable low must keep the shifter quiet even inside a window
        end_cmd = 1'b1;
        beg_cmd = 1'b0;
        clear(ctl(0, 0, 0, 0, 0, 0, 0));
        beg_cmd = 1'b1;
        step(3);
        chk("window_indicator", 32'h1, {31'h0, window_indicator});
        chk("shift_enable", 32'h0, {31'h0, shift_enable});
        chk("shift_clock", 32'h0, {31'h0, shift_clock});
        report_and_stop;
    end
endmodule
`default_nettype wire
